// [src/exit_info_consts.svh]
// Purpose: constants for the exit-information and shadow-structure control block
// Assumes: fields are presented on a simple synchronous read port, no bus
// Notes: field selectors are local index codes for the read port
// How it works
// - delivered vector goes into bits 7:0
// - delivery type coded in bits 10:8
// - bit 11 flags a valid error code
// - bits 30:13 zero, bit 12 undefined
// - info field describes event; bit 31 valid
// - hardware exception error code stored, 32 bits
// - instruction exits record instruction byte length
// - length also kept for software interrupt/exception
// - instruction info filled for listed instruction exits
// - sysmgmt-interrupt I/O exits save count, indices, pointer
// - instruction error field untouched by exits
// - region bit 31 selects ordinary or shadow
// - guest entry fails on shadow current structure
// - shadowing off: guest field access exits
// - shadowing on: guest access uses linked structure if present and shadow, else exits
// - shadowing on: entry checks linked structure shadow
// - host operation accesses both structure kinds
// - clear deactivates and writes back cached data
// - fields accessed only through field instructions
`ifndef EXIT_INFO_CONSTS_SVH
`define EXIT_INFO_CONSTS_SVH

`define VEC_LSB 0
`define VEC_MSB 7
`define TYPE_LSB 8
`define TYPE_MSB 10
`define ERRV_BIT 11
`define UNDEF_BIT 12
`define VALID_BIT 31
`define SHADOW_IND_BIT 31

`define SEL_INFO 4'h0
`define SEL_ERR 4'h1
`define SEL_LEN 4'h2
`define SEL_INSTR 4'h3
`define SEL_CNT 4'h4
`define SEL_SRC 4'h5
`define SEL_DST 4'h6
`define SEL_IP 4'h7
`define SEL_IERR 4'h8

`endif

// [src/exit_info_pkg.sv]
// Purpose: types for the exit-information block
// Assumes: exit_info_consts.svh is included by users
// Notes: none
package exit_info_pkg;

  typedef enum logic [2:0] {
    DT_EXT_INT = 3'h0,
    DT_UNUSED1 = 3'h1,
    DT_NMI = 3'h2,
    DT_HW_EXC = 3'h3,
    DT_SW_INT = 3'h4,
    DT_PRIV_SW_EXC = 3'h5,
    DT_SW_EXC = 3'h6,
    DT_UNUSED7 = 3'h7
  } delivery_type_t;

  typedef struct packed {
    logic in_delivery;
    logic [7:0] vector;
    delivery_type_t dtype;
    logic err_valid;
    logic [31:0] err_code;
  } delivery_t;

  typedef struct packed {
    logic is_instr_exit;
    logic has_instr_info;
    logic io_sys_mgmt;
    logic [31:0] instr_len;
    logic [31:0] instr_info;
    logic [63:0] io_count;
    logic [63:0] io_src;
    logic [63:0] io_dst;
    logic [63:0] io_ip;
  } exit_cause_t;

  typedef enum logic [1:0] {
    ACC_NONE = 2'h0,
    ACC_CURRENT = 2'h1,
    ACC_LINKED = 2'h2,
    ACC_EXIT = 2'h3
  } access_route_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_FLUSH = 2'h2
  } struct_state_t;

endpackage

// [src/access_gate.sv]
// Purpose: decides where a field read or write goes and whether entry fails
// Assumes: indicators come from the first word of each region
// Notes: purely combinational
`timescale 1ns/1ps
`include "exit_info_consts.svh"
module access_gate
  import exit_info_pkg::*;
(
  // request
  input wire logic field_access,
  input wire logic guest_mode,
  input wire logic shadow_ctrl,
  input wire logic entry_req,
  // structure headers
  input wire logic [31:0] current_hdr,
  input wire logic link_present,
  input wire logic [31:0] link_hdr,
  // result
  output access_route_t route,
  output logic entry_fail
);
  logic cur_shadow;
  logic link_shadow;

  always_comb begin
    cur_shadow = current_hdr[`SHADOW_IND_BIT];
    link_shadow = link_hdr[`SHADOW_IND_BIT];
    route = ACC_NONE;
    if (field_access) begin
      if (!guest_mode) begin
        route = ACC_CURRENT;
      end else if (!shadow_ctrl) begin
        route = ACC_EXIT;
      end else if (link_present && link_shadow) begin
        route = ACC_LINKED;
      end else begin
        route = ACC_EXIT;
      end
    end
    entry_fail = 1'b0;
    if (entry_req) begin
      entry_fail = cur_shadow
        || (shadow_ctrl && link_present && !link_shadow);
    end
  end
endmodule

// [src/struct_tracker.sv]
// Purpose: tracks whether the current structure is active and drives write-back on clear
// Assumes: write-back completion is reported by the memory side
// Notes: on-chip copy is opaque; only field instructions reach it
`timescale 1ns/1ps
`include "exit_info_consts.svh"
module struct_tracker
  import exit_info_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // commands
  input wire logic load_req,
  input wire logic clear_req,
  input wire logic wb_done,
  // status
  output logic active,
  output logic wb_req
);
  typedef struct packed {
    struct_state_t st;
  } tr_t;
  tr_t r, next_r;

  always_comb begin
    next_r = r;
    unique case (r.st)
      ST_IDLE: if (load_req) next_r.st = ST_ACTIVE;
      ST_ACTIVE: if (clear_req) next_r.st = ST_FLUSH;
      ST_FLUSH: if (wb_done) next_r.st = ST_IDLE;
      default: next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: ST_IDLE};
    end else begin
      r <= next_r;
    end
  end

  assign active = (r.st == ST_ACTIVE);
  assign wb_req = (r.st == ST_FLUSH);
endmodule

// [src/exit_info_top.sv]
// Purpose: records exit information fields and gates structure field access
// Assumes: all inputs synchronous to SYS_CLK
// Notes: exit_strobe is a one-cycle pulse marking an exit
`timescale 1ns/1ps
`include "exit_info_consts.svh"
module exit_info_top
  import exit_info_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // exit event
  input wire logic EXIT_STROBE,
  input delivery_t DELIVERY,
  input exit_cause_t CAUSE,
  // instruction error report
  input wire logic IERR_STROBE,
  input wire logic [31:0] IERR_VALUE,
  // field read port
  input wire logic [3:0] FIELD_SEL,
  output logic [63:0] FIELD_DATA,
  // access control
  input wire logic FIELD_ACCESS,
  input wire logic GUEST_MODE,
  input wire logic SHADOW_CTRL,
  input wire logic ENTRY_REQ,
  input wire logic [31:0] CURRENT_HDR,
  input wire logic LINK_PRESENT,
  input wire logic [31:0] LINK_HDR,
  output access_route_t ACCESS_ROUTE,
  output logic ENTRY_FAIL,
  // structure lifecycle
  input wire logic LOAD_REQ,
  input wire logic CLEAR_REQ,
  input wire logic WB_DONE,
  output logic STRUCT_ACTIVE,
  output logic WB_REQ
);
  typedef struct packed {
    logic [31:0] info;
    logic [31:0] err;
    logic [31:0] len;
    logic [31:0] instr;
    logic [63:0] cnt;
    logic [63:0] src;
    logic [63:0] dst;
    logic [63:0] ip;
    logic [31:0] ierr;
    logic [63:0] rdata;
  } state_t;
  state_t r, next_r;

  logic sw_delivery;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    sw_delivery = DELIVERY.in_delivery
      && (DELIVERY.dtype == DT_SW_INT || DELIVERY.dtype == DT_SW_EXC
          || DELIVERY.dtype == DT_PRIV_SW_EXC);
    if (EXIT_STROBE) begin
      next_r.info = 32'h0;
      if (DELIVERY.in_delivery) begin
        next_r.info[`VEC_MSB:`VEC_LSB] = DELIVERY.vector;
        next_r.info[`TYPE_MSB:`TYPE_LSB] = DELIVERY.dtype;
        next_r.info[`ERRV_BIT] = DELIVERY.err_valid;
        next_r.info[`VALID_BIT] = 1'b1;
        // bit 12 left undefined; driven zero here
        if (DELIVERY.dtype == DT_HW_EXC && DELIVERY.err_valid) begin
          next_r.err = DELIVERY.err_code;
        end
      end
      if (CAUSE.is_instr_exit || sw_delivery) begin
        next_r.len = CAUSE.instr_len;
      end
      if (CAUSE.has_instr_info) begin
        next_r.instr = CAUSE.instr_info;
      end
      if (CAUSE.io_sys_mgmt) begin
        next_r.cnt = CAUSE.io_count;
        next_r.src = CAUSE.io_src;
        next_r.dst = CAUSE.io_dst;
        next_r.ip = CAUSE.io_ip;
      end
    end
    // exits never touch the instruction error field
    if (IERR_STROBE) begin
      next_r.ierr = IERR_VALUE;
    end
    unique case (FIELD_SEL)
      `SEL_INFO: next_r.rdata = {32'h0, r.info};
      `SEL_ERR: next_r.rdata = {32'h0, r.err};
      `SEL_LEN: next_r.rdata = {32'h0, r.len};
      `SEL_INSTR: next_r.rdata = {32'h0, r.instr};
      `SEL_CNT: next_r.rdata = r.cnt;
      `SEL_SRC: next_r.rdata = r.src;
      `SEL_DST: next_r.rdata = r.dst;
      `SEL_IP: next_r.rdata = r.ip;
      `SEL_IERR: next_r.rdata = {32'h0, r.ierr};
      default: next_r.rdata = 64'h0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign FIELD_DATA = r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  access_gate u_gate (
    .field_access(FIELD_ACCESS),
    .guest_mode(GUEST_MODE),
    .shadow_ctrl(SHADOW_CTRL),
    .entry_req(ENTRY_REQ),
    .current_hdr(CURRENT_HDR),
    .link_present(LINK_PRESENT),
    .link_hdr(LINK_HDR),
    .route(ACCESS_ROUTE),
    .entry_fail(ENTRY_FAIL)
  );

  // indicator changes while active are the software's hazard, not checked here
  struct_tracker u_track (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .load_req(LOAD_REQ),
    .clear_req(CLEAR_REQ),
    .wb_done(WB_DONE),
    .active(STRUCT_ACTIVE),
    .wb_req(WB_REQ)
  );
endmodule

// [sim/exit_info_checker.sv]
// Purpose: port assertions for exit_info_top
// Assumes: one clock domain, async low reset
// Notes: gate outputs are checked in the same cycle
`timescale 1ns/1ps
`include "exit_info_consts.svh"
module exit_info_checker
  import exit_info_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // access gate
  input wire logic FIELD_ACCESS,
  input wire logic GUEST_MODE,
  input wire logic SHADOW_CTRL,
  input wire logic ENTRY_REQ,
  input wire logic [31:0] CURRENT_HDR,
  input wire logic LINK_PRESENT,
  input wire logic [31:0] LINK_HDR,
  input access_route_t ACCESS_ROUTE,
  input wire logic ENTRY_FAIL,
  // lifecycle and reads
  input wire logic CLEAR_REQ,
  input wire logic WB_DONE,
  input wire logic STRUCT_ACTIVE,
  input wire logic WB_REQ,
  input wire logic IERR_STROBE,
  input wire logic [3:0] FIELD_SEL,
  input wire logic [63:0] FIELD_DATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  wire gacc = FIELD_ACCESS && GUEST_MODE;
  wire link_shd = LINK_PRESENT && LINK_HDR[`SHADOW_IND_BIT];
  wire link_ord = LINK_PRESENT && !LINK_HDR[`SHADOW_IND_BIT];
  ////////////////////////////////////////////////////////////
  sequence clear_taken; STRUCT_ACTIVE && CLEAR_REQ; endsequence
  sequence flush_done; WB_REQ && WB_DONE; endsequence
  // two reads of the error field with no load between
  sequence ierr_quiet; FIELD_SEL == `SEL_IERR && !IERR_STROBE ##1 FIELD_SEL == `SEL_IERR; endsequence
  ////////////////////////////////////////////////////////////
  route_host_a: assert property (FIELD_ACCESS && !GUEST_MODE |-> ACCESS_ROUTE == ACC_CURRENT)
    else $error("host access not routed to current");
  guest_exit_a: assert property (gacc && !SHADOW_CTRL |-> ACCESS_ROUTE == ACC_EXIT)
    else $error("guest access without shadowing did not exit");
  linked_route_a: assert property (gacc && SHADOW_CTRL && link_shd |-> ACCESS_ROUTE == ACC_LINKED)
    else $error("guest access not routed to linked");
  entry_shadow_a: assert property (ENTRY_REQ && CURRENT_HDR[`SHADOW_IND_BIT] |-> ENTRY_FAIL)
    else $error("entry on shadow structure not failed");
  link_check_a: assert property (ENTRY_REQ && SHADOW_CTRL && link_ord |-> ENTRY_FAIL)
    else $error("ordinary linked structure not failed");
  clear_flush_a: assert property (clear_taken |=> WB_REQ)
    else $error("clear did not start write-back");
  flush_end_a: assert property (flush_done |=> !WB_REQ && !STRUCT_ACTIVE)
    else $error("write-back did not end inactive");
  ierr_hold_a: assert property (ierr_quiet |=> $stable(FIELD_DATA))
    else $error("error field changed without load");
endmodule
bind exit_info_top exit_info_checker u_chk (.*);

// [sim/tb_exit_info_top.sv]
// Purpose: self-checking bench for exit_info_top
// Assumes: reads answer one edge after the selector
// Notes: route compared every step, none expected without an access
`timescale 1ns/1ps
`include "exit_info_consts.svh"
module tb_exit_info_top import exit_info_pkg::*;;
  logic SYS_CLK = 0, RSTN = 0, EXIT_STROBE = 0, IERR_STROBE = 0, LOAD_REQ = 0;
  logic FIELD_ACCESS = 0, GUEST_MODE = 0, SHADOW_CTRL = 0, ENTRY_REQ = 0, LINK_PRESENT = 0;
  logic CLEAR_REQ = 0, WB_DONE = 0, ENTRY_FAIL, STRUCT_ACTIVE, WB_REQ, exp_fail;
  logic [31:0] IERR_VALUE = 0, CURRENT_HDR = 0, LINK_HDR = 0;
  logic [3:0] FIELD_SEL = 0;
  logic [63:0] FIELD_DATA;
  delivery_t DELIVERY = '0;
  exit_cause_t CAUSE = '0;
  access_route_t ACCESS_ROUTE, exp_route;
  logic [63:0] m [9] = '{default: 64'h0};
  logic [383:0] r;
  int fail_count = 0, n_tests = 0, cyc = 0;
  exit_info_top u_dut (.*);
  always #5 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tick(); @(posedge SYS_CLK); #1; endtask
  function automatic logic [383:0] rnd();
    for (int k = 0; k < 12; k++) rnd[k*32+:32] = $urandom;
  endfunction
  task automatic read_all();
    for (int s = 0; s < 9; s++) begin
      FIELD_SEL = s[3:0];
      tick();
      chk($sformatf("field %0d", s), m[s], FIELD_DATA);
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic do_exit(int t, bit dl);
    r = rnd();
    CAUSE = r[322:0];
    DELIVERY = r[383:339];
    DELIVERY.dtype = delivery_type_t'(t[2:0]);
    // early passes always deliver, so every used type (all but 1 and 7) and the error code get seen
    if (dl) DELIVERY.in_delivery = 1'b1;
    if (dl && t == 3) DELIVERY.err_valid = 1'b1;
    EXIT_STROBE = 1;
    FIELD_SEL = `SEL_IERR;
    m[0] = DELIVERY.in_delivery ? {33'h1, 19'h0, DELIVERY.err_valid, DELIVERY.dtype, DELIVERY.vector} : 64'h0;
    if (DELIVERY.in_delivery && t == 3 && DELIVERY.err_valid) m[1] = {32'h0, DELIVERY.err_code};
    // types 4..6 are software-delivered and carry a length
    if (CAUSE.is_instr_exit || DELIVERY.in_delivery && t > 3) m[2] = {32'h0, CAUSE.instr_len};
    if (CAUSE.has_instr_info) m[3] = {32'h0, CAUSE.instr_info};
    if (CAUSE.io_sys_mgmt) m[4:7] = '{CAUSE.io_count, CAUSE.io_src, CAUSE.io_dst, CAUSE.io_ip};
    tick();
    EXIT_STROBE = 0;
    tick();
    chk("ierr", m[8], FIELD_DATA);
    read_all();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(12036));
    repeat (3) @(posedge SYS_CLK);
    #1 RSTN = 1;
    read_all();
    IERR_VALUE = $urandom;
    IERR_STROBE = 1;
    m[8] = {32'h0, IERR_VALUE};
    tick();
    IERR_STROBE = 0;
    // codes 1 and 7 are unused and never driven
    for (int t = 0; t < 28; t++) if (t % 7 != 1) do_exit(t % 7, t < 14);
    for (int i = 0; i < 128; i++) begin
      {FIELD_ACCESS, GUEST_MODE, SHADOW_CTRL, ENTRY_REQ, LINK_PRESENT} = i[4:0];
      // indicators only change while no structure is active
      CURRENT_HDR = {i[5], 31'($urandom)};
      LINK_HDR = {i[6], 31'($urandom)};
      #1;
      exp_route = !GUEST_MODE ? ACC_CURRENT : SHADOW_CTRL && LINK_PRESENT && i[6] ? ACC_LINKED : ACC_EXIT;
      if (!FIELD_ACCESS) exp_route = ACC_NONE;
      exp_fail = ENTRY_REQ && (i[5] || SHADOW_CTRL && LINK_PRESENT && !i[6]);
      chk("route", 64'(exp_route), 64'(ACCESS_ROUTE));
      chk("entry_fail", 64'(exp_fail), 64'(ENTRY_FAIL));
      tick();
    end
    LOAD_REQ = 1;
    tick();
    LOAD_REQ = 0;
    chk("active", 64'h1, 64'(STRUCT_ACTIVE));
    CLEAR_REQ = 1;
    tick();
    CLEAR_REQ = 0;
    // memory side stalls the write-back
    repeat ($urandom_range(4, 1)) begin
      chk("wb_req", 64'h1, 64'(WB_REQ));
      tick();
    end
    WB_DONE = 1;
    tick();
    WB_DONE = 0;
    chk("idle", 64'h0, 64'({WB_REQ, STRUCT_ACTIVE}));
    test_done();
  end
endmodule
